/* File: dcc_cke_ctrl.sv */
// Device-side CKE loss, power-down, clock change, DLL relock and NOP/deselect control
// Functional notes
// - Async CKE drop voids array contents
// - Operate normally after DLL lock time
// - NOP is CS low, others high
// - NOP does not end running burst
// - CS high is deselect, others ignored
// - CKE low with NOP enters power-down; here only from ST_ACTIVE with no burst busy
// - CKE high with NOP exits power-down
`timescale 1ns/1ps

module dcc_cke_ctrl (
  input  wire logic            mclk,
  input  wire logic            rst_b,
  input  wire logic            cke,
  input  wire logic            odt,
  input  wire dcc_pkg::dcc_cmd_s cmd,
  input  wire logic            allBanksIdle,
  input  wire logic            burstLen8,
  input  wire logic            initDone,
  input  wire logic            clkChanged,
  output dcc_pkg::dcc_status_s status
);

  dcc_pkg::dcc_regs_s regs_q;
  dcc_pkg::dcc_regs_s regs_d;
  dcc_pkg::dcc_cmd_e  cmdNow;
  logic               idleCmd;
  logic               ckeLowAsync;

  function automatic dcc_pkg::dcc_cmd_e decodeCmd(input dcc_pkg::dcc_cmd_s c);
    if (c.csN)
      decodeCmd = dcc_pkg::CMD_DESEL;
    else if (c.rasN && c.casN && c.weN)
      decodeCmd = dcc_pkg::CMD_NOP;
    else if (c.rasN && !c.casN)
      decodeCmd = c.weN ? dcc_pkg::CMD_READ : dcc_pkg::CMD_WRITE;
    else if (!c.rasN && !c.casN && !c.weN)
      decodeCmd = dcc_pkg::CMD_MODE;
    else
      decodeCmd = dcc_pkg::CMD_OTHER;
  endfunction

  assign cmdNow  = decodeCmd(cmd);
  assign idleCmd = (cmdNow == dcc_pkg::CMD_NOP) || (cmdNow == dcc_pkg::CMD_DESEL);
  // CKE dropping with a real command or a burst in flight is not a clean power-down entry
  assign ckeLowAsync = regs_q.ckePrev && !cke && (!idleCmd || regs_q.st.burstBusy);

  always_comb
  begin
    regs_d = regs_q;
    regs_d.ckePrev        = cke;
    regs_d.st.nopSeen     = (cmdNow == dcc_pkg::CMD_NOP);
    regs_d.st.deselSeen   = (cmdNow == dcc_pkg::CMD_DESEL);
    regs_d.st.odtViolation = 1'b0;

    // Burst runs its full length; NOP and deselect leave it alone
    if (regs_q.burstCnt != 3'h0)
      regs_d.burstCnt = regs_q.burstCnt - 3'h1;
    if (regs_q.fsm == dcc_pkg::ST_ACTIVE && cke &&
        (cmdNow == dcc_pkg::CMD_READ || cmdNow == dcc_pkg::CMD_WRITE))
      regs_d.burstCnt = burstLen8 ? dcc_pkg::BURST8_CK : dcc_pkg::BURST4_CK;

    case (regs_q.fsm)
      dcc_pkg::ST_LOST:
      begin
        // Nothing but a completed init sequence brings the device back
        regs_d.burstCnt = 3'h0;
        if (initDone)
        begin
          regs_d.fsm            = dcc_pkg::ST_ACTIVE;
          regs_d.st.needInit    = 1'b0;
          regs_d.st.arrayIntact = 1'b1;
          regs_d.st.dllLocked   = 1'b1;
        end
      end
      dcc_pkg::ST_ACTIVE, dcc_pkg::ST_DLL_WAIT, dcc_pkg::ST_DLL_LOCK:
      begin
        if (regs_q.fsm == dcc_pkg::ST_DLL_WAIT && cke && cmdNow == dcc_pkg::CMD_MODE)
        begin
          if (cmd.bank == dcc_pkg::EMR_BANK)
          begin
            regs_d.fsm    = dcc_pkg::ST_DLL_LOCK;
            regs_d.dllCnt = 8'h00;
          end
          // A plain mode register write to retune latencies keeps us waiting for the EMRS
          else if (cmd.bank == dcc_pkg::MR_BANK)
            regs_d.fsm = dcc_pkg::ST_DLL_WAIT;
        end
        if (regs_q.fsm == dcc_pkg::ST_DLL_LOCK)
        begin
          if (odt)
            regs_d.st.odtViolation = 1'b1;
          if (regs_q.dllCnt == dcc_pkg::DLL_LOCK_LAST)
          begin
            regs_d.fsm          = dcc_pkg::ST_ACTIVE;
            regs_d.st.dllLocked = 1'b1;
          end
          else
            regs_d.dllCnt = regs_q.dllCnt + 8'h01;
        end
        if (ckeLowAsync)
        begin
          regs_d.fsm            = dcc_pkg::ST_LOST;
          regs_d.st.arrayIntact = 1'b0;
          regs_d.st.needInit    = 1'b1;
          regs_d.st.dllLocked   = 1'b0;
          regs_d.burstCnt       = 3'h0;
        end
        else if (regs_q.ckePrev && !cke && regs_q.fsm == dcc_pkg::ST_ACTIVE)
        begin
          regs_d.fsm             = dcc_pkg::ST_PWRDN;
          regs_d.st.pwrDown      = 1'b1;
          regs_d.st.prechPwrDown = allBanksIdle;
          regs_d.pdCnt           = 2'h1;
        end
      end
      dcc_pkg::ST_PWRDN:
      begin
        if (regs_q.pdCnt != 2'h3)
          regs_d.pdCnt = regs_q.pdCnt + 2'h1;
        // Window opens only in precharge power-down, two clocks in, with ODT low
        regs_d.st.clkChangeOk = regs_q.st.prechPwrDown && !odt && !cke &&
                                (regs_d.pdCnt >= 2'(dcc_pkg::FREQ_WAIT_CK));
        if (clkChanged && !regs_q.st.clkChangeOk)
          regs_d.st.odtViolation = 1'b1;
        if (clkChanged && regs_q.st.clkChangeOk)
          regs_d.freqPending = 1'b1;
        if (regs_q.freqPending && odt)
          regs_d.st.odtViolation = 1'b1;
        if (cke && idleCmd)
        begin
          regs_d.st.pwrDown      = 1'b0;
          regs_d.st.prechPwrDown = 1'b0;
          regs_d.st.clkChangeOk  = 1'b0;
          regs_d.pdCnt           = 2'h0;
          // A new clock leaves the DLL unlocked until an EMRS reset and the lock time
          if (regs_q.freqPending || clkChanged)
          begin
            regs_d.fsm          = dcc_pkg::ST_DLL_WAIT;
            regs_d.freqPending  = 1'b0;
            regs_d.st.dllLocked = 1'b0;
          end
          else
            regs_d.fsm = dcc_pkg::ST_ACTIVE;
        end
      end
      default:
      begin
        regs_d.fsm = dcc_pkg::ST_LOST;
      end
    endcase
    regs_d.st.burstBusy = (regs_d.burstCnt != 3'h0);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regs_q                 <= '0;
      regs_q.fsm             <= dcc_pkg::ST_LOST;
      regs_q.ckePrev         <= dcc_pkg::RST_CKE_PREV;
      regs_q.st.arrayIntact  <= dcc_pkg::RST_ARRAY_OK;
      regs_q.st.dllLocked    <= dcc_pkg::RST_DLL_LOCK;
      regs_q.st.needInit     <= 1'b1;
    end
    else
      regs_q <= regs_d;
  end

  assign status = regs_q.st;

  // A burst of four holds busy for exactly two clocks despite NOPs
  a_burst_four_len: assert property (@(posedge mclk) disable iff (!rst_b)
    (regs_q.fsm == dcc_pkg::ST_ACTIVE && cke && !burstLen8 && regs_q.burstCnt == 3'h0 &&
     cmdNow == dcc_pkg::CMD_READ) |=> regs_q.st.burstBusy [*2] ##1 !regs_q.st.burstBusy)
    else $error("burst of four did not run two clocks");

  a_cke_loss_voids: assert property (@(posedge mclk) disable iff (!rst_b)
    ckeLowAsync && regs_q.fsm != dcc_pkg::ST_LOST |=> !status.arrayIntact && status.needInit)
    else $error("CKE loss did not void array");

  a_init_restores: assert property (@(posedge mclk) disable iff (!rst_b)
    regs_q.fsm == dcc_pkg::ST_LOST && !initDone |=> regs_q.fsm == dcc_pkg::ST_LOST)
    else $error("left lost state without init");

  a_pd_entry_nop: assert property (@(posedge mclk) disable iff (!rst_b)
    regs_q.fsm == dcc_pkg::ST_ACTIVE && regs_q.ckePrev && !cke && idleCmd && !status.burstBusy
    |=> status.pwrDown && status.prechPwrDown == $past(allBanksIdle))
    else $error("power-down entry missed");

  a_pd_exit_nop: assert property (@(posedge mclk) disable iff (!rst_b)
    regs_q.fsm == dcc_pkg::ST_PWRDN && cke && idleCmd |=> !status.pwrDown)
    else $error("power-down exit missed");

  // Window may show one edge after entry, so a change is first taken two edges after CKE low
  a_clk_window_wait: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(cke) && regs_q.fsm == dcc_pkg::ST_ACTIVE |-> !status.clkChangeOk ##1 !status.clkChangeOk)
    else $error("clock window opened too early");

  a_dll_lock_time: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(regs_q.fsm == dcc_pkg::ST_DLL_LOCK) && !ckeLowAsync |-> !status.dllLocked [*8])
    else $error("DLL locked before lock time");

  a_nop_deselect: assert property (@(posedge mclk) disable iff (!rst_b)
    cmd.csN |=> status.deselSeen && !status.nopSeen)
    else $error("deselect not decoded");

  a_odt_relock: assert property (@(posedge mclk) disable iff (!rst_b)
    regs_q.fsm == dcc_pkg::ST_DLL_LOCK && odt |=> status.odtViolation)
    else $error("ODT during relock not flagged");

endmodule

/* File: dcc_pkg.sv */
// Shared types and constants for the CKE, clock-change and NOP/deselect control block
package dcc_pkg;

  // Cycles CKE must sit low in precharge power-down before the clock may change
  localparam int unsigned FREQ_WAIT_CK  = 2;
  // DLL lock time in clocks after the DLL reset (plain default)
  localparam int unsigned DLL_LOCK_CK   = 200;
  localparam logic [7:0]  DLL_LOCK_LAST = 8'(DLL_LOCK_CK - 1);

  // Burst lengths in clocks (two data beats per clock)
  localparam logic [2:0]  BURST4_CK     = 3'h2;
  localparam logic [2:0]  BURST8_CK     = 3'h4;

  // Bank address that selects the extended mode register
  localparam logic [2:0]  EMR_BANK      = 3'h1;
  localparam logic [2:0]  MR_BANK       = 3'h0;

  // Reset values
  localparam logic        RST_ARRAY_OK  = 1'b0;
  localparam logic        RST_DLL_LOCK  = 1'b0;
  localparam logic        RST_CKE_PREV  = 1'b0;

  typedef enum logic [2:0] {
    ST_LOST,
    ST_ACTIVE,
    ST_PWRDN,
    ST_DLL_WAIT,
    ST_DLL_LOCK
  } dcc_state_e;

  typedef enum logic [2:0] {
    CMD_DESEL,
    CMD_NOP,
    CMD_READ,
    CMD_WRITE,
    CMD_MODE,
    CMD_OTHER
  } dcc_cmd_e;

  // Command pins as sampled on the rising clock edge
  typedef struct packed {
    logic       csN;
    logic       rasN;
    logic       casN;
    logic       weN;
    logic [2:0] bank;
  } dcc_cmd_s;

  // Status seen by the rest of the device
  typedef struct packed {
    logic pwrDown;
    logic prechPwrDown;
    logic arrayIntact;
    logic needInit;
    logic dllLocked;
    logic clkChangeOk;
    logic burstBusy;
    logic nopSeen;
    logic deselSeen;
    logic odtViolation;
  } dcc_status_s;

  typedef struct packed {
    dcc_state_e fsm;
    logic       ckePrev;
    logic [1:0] pdCnt;
    logic [2:0] burstCnt;
    logic [7:0] dllCnt;
    logic       freqPending;
    dcc_status_s st;
  } dcc_regs_s;

endpackage

/* File: dcc_ctl_model.sv */
// Behavioural memory controller driving the control and command pins
`timescale 1ns/1ps

module dcc_ctl_model (
  output logic              cke,
  output logic              odt,
  output logic              clkChanged,
  output dcc_pkg::dcc_cmd_s cmd
);
  initial
  begin
    cke        = 1'b1;
    odt        = 1'b0;
    clkChanged = 1'b0;
    cmd        = 7'h78;
  end

  // Called just after a rising edge; pins hold until the next call
  task automatic drive(input logic c, input logic [3:0] pins, input logic [2:0] ba);
    cke <= c;
    cmd <= {pins, ba};
  endtask

  // Termination is raised only to provoke the misuse checks
  task automatic termination(input logic v);
    odt <= v;
  endtask

  // Frequency change is only announced; the bench decides when
  task automatic announce(input logic v);
    clkChanged <= v;
  endtask
endmodule

/* File: dcc_cke_ctrl_bench.sv */
// Self-checking bench for the CKE, clock-change and NOP/deselect control block
`timescale 1ns/1ps

module dcc_cke_ctrl_bench;
  logic                 mclk         = 1'b0;
  logic                 rst_b        = 1'b0;
  logic                 allBanksIdle = 1'b1;
  logic                 burstLen8    = 1'b0;
  logic                 initDone     = 1'b0;
  logic                 cke;
  logic                 odt;
  logic                 clkChanged;
  dcc_pkg::dcc_cmd_s    cmd;
  dcc_pkg::dcc_status_s status;
  int                   num_errors   = 0;
  int                   check_count  = 0;
  int                   cycles       = 0;

  always #25 mclk = ~mclk;

  dcc_ctl_model ctl_u (.cke(cke), .odt(odt), .clkChanged(clkChanged), .cmd(cmd));

  dcc_cke_ctrl dut_u (
    .mclk(mclk), .rst_b(rst_b), .cke(cke), .odt(odt), .cmd(cmd),
    .allBanksIdle(allBanksIdle), .burstLen8(burstLen8), .initDone(initDone),
    .clkChanged(clkChanged), .status(status)
  );

  task automatic chk(input string what, input logic seen, input logic exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
    end
  endtask

  // Sample just after the edge so registered status has settled
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic pulse_init();
    initDone <= 1'b1;
    tick(1);
    initDone <= 1'b0;
    tick(1);
  endtask

  task automatic t_init();
    ctl_u.drive(1'b1, 4'h7, 3'h0);
    pulse_init();
    chk("needInit", status.needInit, 1'b0);
    chk("arrayIntact", status.arrayIntact, 1'b1);
  endtask

  task automatic t_decode();
    ctl_u.drive(1'b1, 4'h7, 3'h0);
    tick(1);
    chk("nopSeen", status.nopSeen, 1'b1);
    chk("deselSeen", status.deselSeen, 1'b0);
    // Strobes low under deselect must not look like a mode command
    ctl_u.drive(1'b1, 4'h8, 3'h1);
    tick(1);
    chk("deselSeen", status.deselSeen, 1'b1);
    chk("nopSeen", status.nopSeen, 1'b0);
  endtask

  task automatic t_burst();
    for (int bl = 0; bl < 2; bl++)
    begin
      burstLen8 <= bl[0];
      ctl_u.drive(1'b1, bl[0] ? 4'h4 : 4'h5, 3'h0);
      tick(1);
      ctl_u.drive(1'b1, 4'h7, 3'h0);
      for (int k = 0; k < 5; k++)
      begin
        chk("burstBusy", status.burstBusy, k < (bl[0] ? 4 : 2));
        tick(1);
      end
    end
  endtask

  task automatic t_cke_loss();
    ctl_u.drive(1'b1, 4'h5, 3'h0);
    tick(1);
    ctl_u.drive(1'b0, 4'h7, 3'h0);
    tick(2);
    chk("arrayIntact", status.arrayIntact, 1'b0);
    chk("needInit", status.needInit, 1'b1);
    ctl_u.drive(1'b1, 4'h7, 3'h0);
    tick(2);
    t_init();
  endtask

  // Active power-down never opens the clock window
  task automatic t_active_pd();
    allBanksIdle <= 1'b0;
    ctl_u.drive(1'b0, 4'h7, 3'h0);
    tick(1);
    chk("prechPwrDown", status.prechPwrDown, 1'b0);
    tick(2);
    chk("clkChangeOk", status.clkChangeOk, 1'b0);
    allBanksIdle <= 1'b1;
    ctl_u.drive(1'b1, 4'h7, 3'h0);
    tick(1);
    chk("pwrDown", status.pwrDown, 1'b0);
    chk("dllLocked", status.dllLocked, 1'b1);
  endtask

  task automatic t_clock_change();
    ctl_u.drive(1'b0, 4'h7, 3'h0);
    tick(1);
    chk("pwrDown", status.pwrDown, 1'b1);
    chk("prechPwrDown", status.prechPwrDown, 1'b1);
    chk("clkChangeOk", status.clkChangeOk, 1'b0);
    // Announced one clock early: flagged, not accepted
    ctl_u.announce(1'b1);
    tick(1);
    chk("odtViolation", status.odtViolation, 1'b1);
    chk("clkChangeOk", status.clkChangeOk, 1'b1);
    tick(1);
    chk("odtViolation", status.odtViolation, 1'b0);
    ctl_u.announce(1'b0);
    ctl_u.termination(1'b1);
    tick(1);
    chk("odtViolation", status.odtViolation, 1'b1);
    ctl_u.termination(1'b0);
    ctl_u.drive(1'b1, 4'h7, 3'h0);
    tick(1);
    chk("pwrDown", status.pwrDown, 1'b0);
    chk("dllLocked", status.dllLocked, 1'b0);
    ctl_u.drive(1'b1, 4'h0, dcc_pkg::MR_BANK);
    tick(1);
    ctl_u.drive(1'b1, 4'h0, dcc_pkg::EMR_BANK);
    tick(1);
    ctl_u.drive(1'b1, 4'h7, 3'h0);
    ctl_u.termination(1'b1);
    tick(1);
    chk("odtViolation", status.odtViolation, 1'b1);
    ctl_u.termination(1'b0);
    tick(dcc_pkg::DLL_LOCK_CK - 2);
    chk("dllLocked", status.dllLocked, 1'b0);
    tick(1);
    chk("dllLocked", status.dllLocked, 1'b1);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  initial
  begin
    tick(5);
    chk("needInit", status.needInit, 1'b1);
    chk("arrayIntact", status.arrayIntact, 1'b0);
    @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    t_init();
    t_decode();
    t_burst();
    t_cke_loss();
    t_active_pd();
    t_clock_change();
    report_and_stop();
  end
endmodule
